// ---- hdl/cal_regs_pkg.sv ----
// constants and types of the channel calibration and setup register bank
// Behaviour
// [R1] Offset bits 23 to 8 sit in a 16-bit read/write high register.
// [R2] Offset bits 7 to 0 sit in bits 15 to 8 of a read/write low register.
// [R3] The joined 24-bit offset is a signed two's complement number.
// [R4] The 24-bit gain is an unsigned factor from zero to just below two.
// [R5] Gain bits 23 to 8 sit in a read/write high register reset to 8000h.
// [R6] Gain bits 7 to 0 sit in bits 15 to 8 of the low register, reset zero.
// [R7] Bits 7 to 0 of every offset and gain low register always read as zero.
// [R8] Setup bits 15 to 6 hold a signed delay in modulator clocks, reset zero.
// [R9] Setup bits 5 to 3 always read as zero.
// [R10] Setup bit 2 set turns the dc filter off for this channel only.
// [R11] Setup bits 1 to 0 pick pins, shorted, positive or negative test input.
// [R12] Every setup register resets to all zeros.
// [R13] The global 4-bit dc filter setting applies where the off bit is clear.
// [R14] Writes to reserved bits are dropped so they still read zero.
package cal_regs_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int CH_COUNT = 2;
    localparam int ADDR_W   = 8;
    localparam int IDX_W    = 5;
    localparam int IDX_LSB  = 2;

    // ****************************************
    // register indexes, byte address is four times the index
    // ****************************************
    localparam logic [IDX_W-1:0] IDX_THRESH_LOW       = 5'h08;
    localparam logic [IDX_W-1:0] IDX_CH0_SETUP        = 5'h09;
    localparam logic [IDX_W-1:0] IDX_CH0_OFS_HIGH     = 5'h0a;
    localparam logic [IDX_W-1:0] IDX_CH0_OFFSET_LOW   = 5'h0b;
    localparam logic [IDX_W-1:0] IDX_CH0_GAIN_HIGH    = 5'h0c;
    localparam logic [IDX_W-1:0] IDX_CH0_GAIN_LOW     = 5'h0d;
    localparam logic [IDX_W-1:0] IDX_CH1_SETUP        = 5'h0e;
    localparam logic [IDX_W-1:0] IDX_CH1_OFS_HIGH     = 5'h0f;
    localparam logic [IDX_W-1:0] IDX_CH1_OFFSET_LOW   = 5'h10;
    localparam logic [IDX_W-1:0] IDX_CH1_GAIN_HIGH    = 5'h11;
    localparam logic [IDX_W-1:0] IDX_CH1_GAIN_LOW     = 5'h12;

    // slot of each register inside a channel group
    localparam logic [IDX_W-1:0] SLOT_SETUP    = 5'h00;
    localparam logic [IDX_W-1:0] SLOT_OFS_HIGH = 5'h01;
    localparam logic [IDX_W-1:0] SLOT_OFS_LOW  = 5'h02;
    localparam logic [IDX_W-1:0] SLOT_GN_HIGH  = 5'h03;
    localparam logic [IDX_W-1:0] SLOT_GN_LOW   = 5'h04;

    localparam logic [CH_COUNT-1:0][IDX_W-1:0] CH_BASE_IDX =
        {IDX_CH1_SETUP, IDX_CH0_SETUP};

    // ****************************************
    // field layout
    // ****************************************
    localparam int DELAY_LSB  = 6;
    localparam int DELAY_W    = 10;
    localparam int RSV_LSB    = 3;
    localparam int RSV_W      = 3;
    localparam int DC_OFF_BIT = 2;
    localparam int SEL_LSB    = 0;
    localparam int SEL_W      = 2;
    localparam int LOW_LSB    = 8;
    localparam int LOW_W      = 8;
    localparam int DCSET_W    = 4;
    localparam int CORR_W     = 24;
    localparam int ROUTE_W    = 4;

    localparam logic [15:0] SETUP_WR_MASK = 16'hffc7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0]        SETUP_RST     = 16'h0000;
    localparam logic [15:0]        OFS_HIGH_RST  = 16'h0000;
    localparam logic [LOW_W-1:0]   OFS_LOW_RST   = 8'h00;
    localparam logic [15:0]        GAIN_HIGH_RST = 16'h8000;
    localparam logic [LOW_W-1:0]   GAIN_LOW_RST  = 8'h00;
    localparam logic [DCSET_W-1:0] DCSET_RST     = 4'h0;

    // ****************************************
    // input routing
    // ****************************************
    typedef enum logic [SEL_W-1:0] {
        SEL_PINS     = 2'h0,
        SEL_SHORT    = 2'h1,
        SEL_TEST_POS = 2'h2,
        SEL_TEST_NEG = 2'h3
    } input_sel_t;

    localparam logic [ROUTE_W-1:0] ROUTE_PINS     = 4'h1;
    localparam logic [ROUTE_W-1:0] ROUTE_SHORT    = 4'h2;
    localparam logic [ROUTE_W-1:0] ROUTE_TEST_POS = 4'h4;
    localparam logic [ROUTE_W-1:0] ROUTE_TEST_NEG = 4'h8;

endpackage

// ---- hdl/chan_link_if.sv ----
// register contents handed from the bank to one channel's apply stage
`timescale 1ns/1ps
interface chan_link_if;
    logic [15:0] setup;
    logic [15:0] ofs_high;
    logic [7:0]  ofs_low;
    logic [15:0] gain_high;
    logic [7:0]  gain_low;
    logic [3:0]  dc_global;

    modport src
    (
        output setup, ofs_high, ofs_low, gain_high, gain_low, dc_global
    );
    modport dst
    (
        input  setup, ofs_high, ofs_low, gain_high, gain_low, dc_global
    );
endinterface

// ---- hdl/chan_apply.sv ----
// per-channel decode of setup and correction words into datapath controls
`timescale 1ns/1ps
module chan_apply
    import cal_regs_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    input  wire logic                      clk_en,
    chan_link_if.dst                       link,
    output logic signed [CORR_W-1:0]       offset_q,
    output logic        [CORR_W-1:0]       gain_q,
    output logic signed [DELAY_W-1:0]      delay_q,
    output logic                           dc_active_q,
    output logic        [DCSET_W-1:0]      dc_setting_q,
    output logic        [ROUTE_W-1:0]      route_q
);

    // ****************************************
    // next values
    // ****************************************
    logic signed [CORR_W-1:0]  offset_d;
    logic        [CORR_W-1:0]  gain_d;
    logic signed [DELAY_W-1:0] delay_d;
    logic                      dc_active_d;
    logic        [DCSET_W-1:0] dc_setting_d;
    logic        [ROUTE_W-1:0] route_d;
    input_sel_t                sel;

    always_comb
    begin
        offset_d = signed'({link.ofs_high, link.ofs_low}); // R3
        gain_d   = {link.gain_high, link.gain_low}; // R4
        delay_d  = signed'(link.setup[DELAY_LSB +: DELAY_W]); // R8
        dc_active_d  = !link.setup[DC_OFF_BIT]; // R10
        dc_setting_d = dc_active_d ? link.dc_global : '0; // R13
        sel = input_sel_t'(link.setup[SEL_LSB +: SEL_W]);
        unique case (sel) // R11
            SEL_PINS:     route_d = ROUTE_PINS;
            SEL_SHORT:    route_d = ROUTE_SHORT;
            SEL_TEST_POS: route_d = ROUTE_TEST_POS;
            SEL_TEST_NEG: route_d = ROUTE_TEST_NEG;
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            offset_q     <= '0;
            gain_q       <= {GAIN_HIGH_RST, GAIN_LOW_RST};
            delay_q      <= '0;
            dc_active_q  <= 1'b1;
            dc_setting_q <= '0;
            route_q      <= ROUTE_PINS;
        end
        else if (clk_en)
        begin
            offset_q     <= offset_d;
            gain_q       <= gain_d;
            delay_q      <= delay_d;
            dc_active_q  <= dc_active_d;
            dc_setting_q <= dc_setting_d;
            route_q      <= route_d;
        end
    end

endmodule

// ---- hdl/cal_config_regs.sv ----
// apb register bank for channel setup, offset and gain correction
`timescale 1ns/1ps
module cal_config_regs
    import cal_regs_pkg::*;
(
    input  wire logic                                   ref_clk,
    input  wire logic                                   reset,
    input  wire logic                                   clk_en,
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [ADDR_W-1:0]                      paddr,
    input  wire logic [31:0]                            pwdata,
    input  wire logic [3:0]                             pstrb,
    output logic      [31:0]                            prdata,
    output logic                                        pready,
    output logic                                        pslverr,
    output logic      [CH_COUNT-1:0][CORR_W-1:0]        ch_offset,
    output logic      [CH_COUNT-1:0][CORR_W-1:0]        ch_gain,
    output logic      [CH_COUNT-1:0][DELAY_W-1:0]       ch_delay_cycles,
    output logic      [CH_COUNT-1:0]                    ch_dc_filter_active,
    output logic      [CH_COUNT-1:0][DCSET_W-1:0]       ch_dc_filter_setting,
    output logic      [CH_COUNT-1:0][ROUTE_W-1:0]       ch_route
);

    // ****************************************
    // bus decode
    // ****************************************
    logic [IDX_W-1:0]    acc_idx;
    logic                addr_ok;
    logic                map_hit;
    logic                low_hit;
    logic [15:0]         rd_word;
    logic                wr_done;
    logic [CH_COUNT-1:0] hit_setup;
    logic [CH_COUNT-1:0] hit_ofs_high;
    logic [CH_COUNT-1:0] hit_ofs_low;
    logic [CH_COUNT-1:0] hit_gain_high;
    logic [CH_COUNT-1:0] hit_gain_low;
    logic                hit_thresh;

    // register state
    logic [CH_COUNT-1:0][15:0]       setup_q;
    logic [CH_COUNT-1:0][15:0]       ofs_high_q;
    logic [CH_COUNT-1:0][LOW_W-1:0]  ofs_low_q;
    logic [CH_COUNT-1:0][15:0]       gain_high_q;
    logic [CH_COUNT-1:0][LOW_W-1:0]  gain_low_q;
    logic [DCSET_W-1:0]              dc_global_q;
    logic [DCSET_W-1:0]              dc_global_d;

    // transfer state
    logic        cap_q;
    logic        cap_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;

    function automatic logic [15:0] merge16
    (
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  st
    );
        logic [15:0] r;
        r = old;
        if (st[0])
            r[7:0] = wd[7:0];
        if (st[1])
            r[15:8] = wd[15:8];
        return r;
    endfunction

    assign acc_idx    = paddr[IDX_LSB +: IDX_W];
    assign addr_ok    = (paddr[1:0] == 2'h0) && !paddr[ADDR_W-1];
    assign hit_thresh = addr_ok && (acc_idx == IDX_THRESH_LOW);
    assign map_hit    = hit_thresh | (|hit_setup) | (|hit_ofs_high)
                      | (|hit_ofs_low) | (|hit_gain_high) | (|hit_gain_low);
    assign low_hit    = (|hit_ofs_low) | (|hit_gain_low);

    // ****************************************
    // apb handshake
    // ****************************************
    assign pready  = psel && penable && cap_q && clk_en;
    assign pslverr = pready && !map_hit;
    assign wr_done = pready && pwrite && map_hit;
    assign prdata  = prdata_q;

    always_comb
    begin
        rd_word = '0;
        if (hit_thresh)
            rd_word[DCSET_W-1:0] = dc_global_q;
        for (int c = 0; c < CH_COUNT; c++)
        begin
            if (hit_setup[c])
                rd_word = setup_q[c];
            if (hit_ofs_high[c])
                rd_word = ofs_high_q[c];
            if (hit_ofs_low[c])
                rd_word = {ofs_low_q[c], 8'h00}; // R7
            if (hit_gain_high[c])
                rd_word = gain_high_q[c];
            if (hit_gain_low[c])
                rd_word = {gain_low_q[c], 8'h00}; // R7
        end
    end

    // read data is caught in the first enabled cycle of a transfer
    always_comb
    begin
        cap_d    = cap_q;
        prdata_d = prdata_q;
        if (pready)
            cap_d = 1'b0;
        else if (psel && !cap_q)
        begin
            cap_d    = 1'b1;
            prdata_d = {16'h0000, rd_word};
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            cap_q    <= 1'b0;
            prdata_q <= '0;
        end
        else if (clk_en)
        begin
            cap_q    <= cap_d;
            prdata_q <= prdata_d;
        end
    end

    // ****************************************
    // global dc filter setting
    // ****************************************
    always_comb
    begin
        dc_global_d = dc_global_q;
        if (wr_done && hit_thresh && pstrb[0])
            dc_global_d = pwdata[DCSET_W-1:0]; // R13
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            dc_global_q <= DCSET_RST;
        else if (clk_en)
            dc_global_q <= dc_global_d;
    end

    // ****************************************
    // per-channel registers and apply stage
    // ****************************************
    chan_link_if link [CH_COUNT] ();

    for (genvar g = 0; g < CH_COUNT; g++)
    begin : g_chan
        logic [15:0]      setup_d;
        logic [15:0]      ofs_high_d;
        logic [LOW_W-1:0] ofs_low_d;
        logic [15:0]      gain_high_d;
        logic [LOW_W-1:0] gain_low_d;

        assign hit_setup[g]     = addr_ok
                                && (acc_idx == CH_BASE_IDX[g] + SLOT_SETUP);
        assign hit_ofs_high[g]  = addr_ok
                                && (acc_idx == CH_BASE_IDX[g] + SLOT_OFS_HIGH);
        assign hit_ofs_low[g]   = addr_ok
                                && (acc_idx == CH_BASE_IDX[g] + SLOT_OFS_LOW);
        assign hit_gain_high[g] = addr_ok
                                && (acc_idx == CH_BASE_IDX[g] + SLOT_GN_HIGH);
        assign hit_gain_low[g]  = addr_ok
                                && (acc_idx == CH_BASE_IDX[g] + SLOT_GN_LOW);

        always_comb
        begin
            setup_d     = setup_q[g];
            ofs_high_d  = ofs_high_q[g];
            ofs_low_d   = ofs_low_q[g];
            gain_high_d = gain_high_q[g];
            gain_low_d  = gain_low_q[g];
            if (wr_done && hit_setup[g])
                setup_d = merge16(setup_q[g], pwdata, pstrb)
                        & SETUP_WR_MASK; // R9 R14
            if (wr_done && hit_ofs_high[g])
                ofs_high_d = merge16(ofs_high_q[g], pwdata, pstrb); // R1
            if (wr_done && hit_ofs_low[g] && pstrb[1])
                ofs_low_d = pwdata[LOW_LSB +: LOW_W]; // R2 R14
            if (wr_done && hit_gain_high[g])
                gain_high_d = merge16(gain_high_q[g], pwdata, pstrb); // R5
            if (wr_done && hit_gain_low[g] && pstrb[1])
                gain_low_d = pwdata[LOW_LSB +: LOW_W]; // R6 R14
        end

        always_ff @(posedge ref_clk or posedge reset)
        begin
            if (reset)
            begin
                setup_q[g]     <= SETUP_RST; // R12
                ofs_high_q[g]  <= OFS_HIGH_RST;
                ofs_low_q[g]   <= OFS_LOW_RST;
                gain_high_q[g] <= GAIN_HIGH_RST; // R5
                gain_low_q[g]  <= GAIN_LOW_RST; // R6
            end
            else if (clk_en)
            begin
                setup_q[g]     <= setup_d;
                ofs_high_q[g]  <= ofs_high_d;
                ofs_low_q[g]   <= ofs_low_d;
                gain_high_q[g] <= gain_high_d;
                gain_low_q[g]  <= gain_low_d;
            end
        end

        assign link[g].setup     = setup_q[g];
        assign link[g].ofs_high  = ofs_high_q[g];
        assign link[g].ofs_low   = ofs_low_q[g];
        assign link[g].gain_high = gain_high_q[g];
        assign link[g].gain_low  = gain_low_q[g];
        assign link[g].dc_global = dc_global_q;

        chan_apply u_apply
        (
            .ref_clk      (ref_clk),
            .reset        (reset),
            .clk_en       (clk_en),
            .link         (link[g]),
            .offset_q     (ch_offset[g]),
            .gain_q       (ch_gain[g]),
            .delay_q      (ch_delay_cycles[g]),
            .dc_active_q  (ch_dc_filter_active[g]),
            .dc_setting_q (ch_dc_filter_setting[g]),
            .route_q      (ch_route[g])
        );
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_offset_high_write: assert property ( // R1
        wr_done && hit_ofs_high[1] && pstrb[1:0] == 2'h3
        |=> ofs_high_q[1] == $past(pwdata[15:0]))
        else $error("offset high word not stored");

    a_offset_low_write: assert property ( // R2
        wr_done && hit_ofs_low[0] && pstrb[1]
        |=> ofs_low_q[0] == $past(pwdata[15:8]) ##1
            ch_offset[0][7:0] == $past(pwdata[15:8], 2))
        else $error("offset low byte not stored or applied");

    a_offset_signed: assert property ( // R3
        clk_en |=> $signed(ch_offset[1])
            == $past($signed({ofs_high_q[1], ofs_low_q[1]})))
        else $error("offset correction not joined");

    a_gain_factor: assert property ( // R4
        clk_en |=> ch_gain[0] == $past({gain_high_q[0], gain_low_q[0]}))
        else $error("gain correction not joined");

    a_gain_unity_reset: assert property ( // R5
        $fell(reset) |-> gain_high_q[0] == GAIN_HIGH_RST
            && gain_high_q[1] == GAIN_HIGH_RST && ch_gain[1] == 24'h800000)
        else $error("gain does not reset to unity");

    a_gain_low_write: assert property ( // R6
        wr_done && hit_gain_low[1] && pstrb[1]
        |=> gain_low_q[1] == $past(pwdata[15:8]))
        else $error("gain low byte not stored");

    a_low_reserved_read: assert property ( // R7
        psel && !penable && !cap_q && clk_en && low_hit
        |=> prdata[7:0] == 8'h00 && prdata[31:16] == 16'h0000)
        else $error("reserved low bits read nonzero");

    a_delay_field: assert property ( // R8
        clk_en |=> ch_delay_cycles[1]
            == $past(setup_q[1][DELAY_LSB +: DELAY_W]))
        else $error("phase delay not applied");

    a_setup_reserved: assert property ( // R9
        wr_done && hit_setup[0]
        |=> setup_q[0][RSV_LSB +: RSV_W] == 3'h0
            && setup_q[0][2:0] == ($past(pwdata[2:0] & {3{pstrb[0]}})
               | ($past(setup_q[0][2:0]) & {3{!$past(pstrb[0])}})))
        else $error("setup reserved bits took a write");

    a_dc_override: assert property ( // R10
        clk_en && setup_q[0][DC_OFF_BIT]
        |=> !ch_dc_filter_active[0] && ch_dc_filter_setting[0] == 4'h0)
        else $error("dc filter not disabled for channel");

    a_route_select: assert property ( // R11
        clk_en && setup_q[1][1:0] == 2'h1 |=> ch_route[1] == ROUTE_SHORT)
        else $error("shorted input not routed");

    a_setup_reset: assert property ( // R12
        $fell(reset) |-> setup_q == '0 && ch_route[0] == ROUTE_PINS)
        else $error("setup not reset to zero");

    a_dc_global: assert property ( // R13
        clk_en && !setup_q[1][DC_OFF_BIT]
        |=> ch_dc_filter_active[1]
            && ch_dc_filter_setting[1] == $past(dc_global_q))
        else $error("global dc setting not applied");

endmodule

// ---- verif/apb_host_model.sv ----
// apb host that issues single register transfers to the bank
`timescale 1ns/1ps
module apb_host_model
    import cal_regs_pkg::*;
(
    input  wire logic              ref_clk,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [ADDR_W-1:0] paddr,
    output logic      [31:0]       pwdata,
    output logic      [3:0]        pstrb,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
    end

    // setup, access until pready, then release with scrambled lines
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [31:0] wd, input logic [3:0] st,
                        output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~wd;
    endtask
endmodule

// ---- verif/test_channel_calibration_config_regs.sv ----
// self-checking bench for the calibration register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module test_channel_calibration_config_regs
    import cal_regs_pkg::*;
;
    logic                               ref_clk = 1'b0;
    logic                               reset   = 1'b1;
    logic                               clk_en  = 1'b1;
    logic                               psel, penable, pwrite, pready;
    logic                               pslverr;
    logic [ADDR_W-1:0]                  paddr;
    logic [31:0]                        pwdata, prdata, rd;
    logic [3:0]                         pstrb;
    logic                               er;
    logic [CH_COUNT-1:0][CORR_W-1:0]    ch_offset, ch_gain;
    logic [CH_COUNT-1:0][DELAY_W-1:0]   ch_delay_cycles;
    logic [CH_COUNT-1:0]                ch_dc_filter_active;
    logic [CH_COUNT-1:0][DCSET_W-1:0]   ch_dc_filter_setting;
    logic [CH_COUNT-1:0][ROUTE_W-1:0]   ch_route;
    logic [15:0]                        rv, mv, sv;
    logic [15:0] rst_v [5] = '{16'h0, 16'h0, 16'h0, 16'h8000, 16'h0};
    logic [15:0] msk_v [5] = '{16'hffc7, 16'hffff, 16'hff00, 16'hffff,
                               16'hff00};
    int                                 errors  = 0;
    int                                 n_tests = 0;

    always #10 ref_clk = ~ref_clk;

    cal_config_regs DUT (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ch_offset(ch_offset), .ch_gain(ch_gain),
        .ch_delay_cycles(ch_delay_cycles),
        .ch_dc_filter_active(ch_dc_filter_active),
        .ch_dc_filter_setting(ch_dc_filter_setting), .ch_route(ch_route));

    apb_host_model host (.ref_clk(ref_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ****************************************
    // access tasks
    // ****************************************
    function automatic logic [ADDR_W-1:0] adr(input logic [IDX_W-1:0] i);
        return {1'b0, i, 2'b00};
    endfunction

    task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d,
                      input logic [3:0] st);
        host.xfer(1'b1, adr(i), d, st, rd, er);
        `CHK("write error flag", 1'b0, er)
    endtask

    task automatic rdc(input logic [IDX_W-1:0] i, input logic [15:0] e);
        host.xfer(1'b0, adr(i), 32'h0, 4'h0, rd, er);
        `CHK("read data", {16'h0, e}, rd)
        `CHK("read error flag", 1'b0, er)
    endtask

    task automatic test_done;
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        test_done;
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        for (int c = 0; c < CH_COUNT; c++)
        begin
            `CHK("gain", 24'h800000, ch_gain[c])
            `CHK("offset", 24'h0, ch_offset[c])
            `CHK("route", ROUTE_PINS, ch_route[c])
            `CHK("dc active", 1'b1, ch_dc_filter_active[c])
            `CHK("delay", 10'h0, ch_delay_cycles[c])
        end
        // reset values, then all ones to see which bits stick
        for (int i = 0; i < 11; i++)
        begin
            rv = (i == 0) ? 16'h0 : rst_v[(i-1)%5];
            mv = (i == 0) ? 16'h000f : msk_v[(i-1)%5];
            rdc(IDX_THRESH_LOW + 5'(i), rv);
            wr(IDX_THRESH_LOW + 5'(i), 32'hffffffff, 4'hf);
            rdc(IDX_THRESH_LOW + 5'(i), mv);
        end
        repeat (2) @(posedge ref_clk);
        `CHK("offset ones", 24'hffffff, ch_offset[0])
        `CHK("gain ones", 24'hffffff, ch_gain[1])
        `CHK("delay ones", 10'h3ff, ch_delay_cycles[1])
        // only the upper byte lane is written
        wr(IDX_CH0_OFS_HIGH, 32'h00005a5a, 4'h2);
        rdc(IDX_CH0_OFS_HIGH, 16'h5aff);
        wr(IDX_CH1_OFS_HIGH, 32'h00008001, 4'hf);
        wr(IDX_CH1_OFFSET_LOW, 32'h000012ff, 4'hf);
        wr(IDX_CH0_GAIN_HIGH, 32'h00001234, 4'hf);
        wr(IDX_CH0_GAIN_LOW, 32'h0000ab5a, 4'hf);
        repeat (2) @(posedge ref_clk);
        `CHK("offset join", 24'h800112, ch_offset[1])
        `CHK("gain join", 24'h1234ab, ch_gain[0])
        rdc(IDX_CH0_GAIN_LOW, 16'hab00);
        wr(IDX_THRESH_LOW, 32'h0000000a, 4'hf);
        // every input code with and without the dc override
        for (int s = 0; s < 4; s++)
            for (int d = 0; d < 2; d++)
            begin
                sv = {10'h200 | 10'(s), 3'b111, d[0], s[1:0]};
                wr(IDX_CH1_SETUP, {16'h0, sv}, 4'hf);
                repeat (2) @(posedge ref_clk);
                `CHK("route", ROUTE_PINS << s, ch_route[1])
                `CHK("delay", 10'h200 | 10'(s), ch_delay_cycles[1])
                `CHK("dc active", ~d[0], ch_dc_filter_active[1])
                `CHK("dc setting", d[0] ? 4'h0 : 4'ha,
                     ch_dc_filter_setting[1])
                rdc(IDX_CH1_SETUP, sv & 16'hffc7);
            end
        // unmapped read and misaligned write are refused
        host.xfer(1'b0, 8'h4c, 32'h0, 4'h0, rd, er);
        `CHK("unmapped error", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        host.xfer(1'b1, 8'h25, 32'h0, 4'hf, rd, er);
        `CHK("misaligned error", 1'b1, er)
        rdc(IDX_CH0_SETUP, 16'hffc7);
        // a low clock enable holds the transfer off until it returns
        clk_en <= 1'b0;
        fork
            wr(IDX_CH1_GAIN_HIGH, 32'h00004321, 4'h3);
            begin
                repeat (4) @(posedge ref_clk);
                `CHK("frozen ready", 1'b0, pready)
                clk_en <= 1'b1;
            end
        join
        repeat (2) @(posedge ref_clk);
        `CHK("gain after freeze", 24'h4321ff, ch_gain[1])
        // second reset in mid-run brings back the reset values
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        `CHK("gain reset", 24'h800000, ch_gain[1])
        `CHK("route reset", ROUTE_PINS, ch_route[1])
        rdc(IDX_CH1_SETUP, 16'h0000);
        rdc(IDX_CH0_GAIN_HIGH, 16'h8000);
        rdc(IDX_CH1_OFFSET_LOW, 16'h0000);
        test_done;
    end
endmodule
